// [design/dcc_pkg.sv]
package dcc_pkg;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 2;

  // register offsets
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h1;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFS_READY = 4'h4;

  // control register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_OUT_STATE = 6;
  localparam int BIT_RISE_FLAG = 5;
  localparam int BIT_FALL_FLAG = 4;
  localparam int POS_HYST_HI = 3;
  localparam int POS_HYST_LO = 2;
  localparam int NEG_HYST_HI = 1;
  localparam int NEG_HYST_LO = 0;

  // hysteresis select codes
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_2MV = 2'h1;
  localparam logic [1:0] HYST_4MV = 2'h2;
  localparam logic [1:0] HYST_10MV = 2'h3;

  // interrupt status / mask layout: two bits per channel
  localparam int IRQ_W = 4;
  localparam int IRQ_RISE_OFS = 0;
  localparam int IRQ_FALL_OFS = 1;
  localparam int IRQ_CH_STRIDE = 2;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // power-on settling of the analog core
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SETTLE_TIME_MS = 20;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_MS * (CLK_HZ / 1000));
  localparam int SETTLE_CNT_W = 18;

  typedef enum logic [2:0] {
    DCC_ST_OFF = 3'b001,
    DCC_ST_SETTLING = 3'b010,
    DCC_ST_READY = 3'b100
  } dcc_settle_t;

endpackage : dcc_pkg

// [design/dcc_cmp_sync.sv]
`timescale 1ns/1ps
module dcc_cmp_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmp_async,
  input wire logic enable,
  output logic level,
  output logic rise_pulse,
  output logic fall_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  always_comb begin
    nxt_meta = cmp_async;
    nxt_sync = meta_ff;
    // prev tracks sync even while disabled so enabling makes no false edge
    nxt_prev = sync_ff;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level = sync_ff;
  assign rise_pulse = enable & sync_ff & ~prev_ff;
  assign fall_pulse = enable & ~sync_ff & prev_ff;

endmodule : dcc_cmp_sync

// [design/dcc_top.sv]
`timescale 1ns/1ps
// Operation
// - two comparator channels, each enabled or shut down on its own
// - disabled channel drives its routed port output low
// - disabled channel raises no edge events
// - rising and falling output edges are separate event sources
// - falling edge sets the fall flag at control bit 4
// - rising edge sets the rise flag at control bit 5
// - edge flags stay set until software clears them
// - bit 6 shows the current output level, read only
// - bit 7 written one enables, zero disables the channel
// - channel 0 may serve as a reset source, selected elsewhere
// - channel 1 never resets, otherwise identical with its own register
// - bits 1-0 pick negative hysteresis: off, 2, 4, 10 mV
// - bits 3-2 pick positive hysteresis the same way
// - each output may go to a port 1 pin, or be polled
module dcc_top #(
  parameter int unsigned SETTLE_CYCLES = dcc_pkg::SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [1:0] cmp_raw,
  input wire logic cmp0_reset_sel,
  output logic [1:0] cmp_enable,
  output logic [1:0] cmp0_pos_hyst_sel,
  output logic [1:0] cmp0_neg_hyst_sel,
  output logic [1:0] cmp1_pos_hyst_sel,
  output logic [1:0] cmp1_neg_hyst_sel,
  output logic [1:0] cmp_port_out,
  output logic cmp0_reset_req,
  output logic irq
);

  localparam logic [dcc_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
    dcc_pkg::SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  // per-channel control state
  logic [1:0] en_ff;
  logic [1:0] rise_flag_ff;
  logic [1:0] fall_flag_ff;
  logic [1:0] pos_hyst_ff [dcc_pkg::NUM_CH];
  logic [1:0] neg_hyst_ff [dcc_pkg::NUM_CH];
  logic [1:0] nxt_en;
  logic [1:0] nxt_rise_flag;
  logic [1:0] nxt_fall_flag;
  logic [1:0] nxt_pos_hyst [dcc_pkg::NUM_CH];
  logic [1:0] nxt_neg_hyst [dcc_pkg::NUM_CH];

  // interrupt state
  logic [3:0] irq_status_ff;
  logic [3:0] irq_mask_ff;
  logic irq_ff;
  logic [3:0] nxt_irq_status;
  logic [3:0] nxt_irq_mask;
  logic nxt_irq;

  // settle tracking
  dcc_pkg::dcc_settle_t settle_st_ff [dcc_pkg::NUM_CH];
  dcc_pkg::dcc_settle_t nxt_settle_st [dcc_pkg::NUM_CH];
  logic [dcc_pkg::SETTLE_CNT_W-1:0] settle_cnt_ff [dcc_pkg::NUM_CH];
  logic [dcc_pkg::SETTLE_CNT_W-1:0] nxt_settle_cnt [dcc_pkg::NUM_CH];
  logic [1:0] ready;

  // outputs held in flops
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [1:0] port_out_ff;
  logic [1:0] nxt_port_out;
  logic reset_req_ff;
  logic nxt_reset_req;

  // synchroniser results
  logic [1:0] level;
  logic [1:0] rise_pulse;
  logic [1:0] fall_pulse;

  function automatic logic ctrl_hit(input logic [3:0] a, input int ch);
    ctrl_hit = (ch == 0) ? (a == dcc_pkg::OFS_CTRL0) : (a == dcc_pkg::OFS_CTRL1);
  endfunction : ctrl_hit

  function automatic logic [7:0] ctrl_image(input logic en, input logic lvl,
                                            input logic rf, input logic ff,
                                            input logic [1:0] ph,
                                            input logic [1:0] nh);
    logic [7:0] v;
    v = dcc_pkg::CTRL_RESET;
    v[dcc_pkg::BIT_ENABLE] = en;
    v[dcc_pkg::BIT_OUT_STATE] = lvl;
    v[dcc_pkg::BIT_RISE_FLAG] = rf;
    v[dcc_pkg::BIT_FALL_FLAG] = ff;
    v[dcc_pkg::POS_HYST_HI:dcc_pkg::POS_HYST_LO] = ph;
    v[dcc_pkg::NEG_HYST_HI:dcc_pkg::NEG_HYST_LO] = nh;
    ctrl_image = v;
  endfunction : ctrl_image

  genvar gi;
  generate
    for (gi = 0; gi < dcc_pkg::NUM_CH; gi++) begin : g_ch
      dcc_cmp_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .cmp_async(cmp_raw[gi]),
        .enable(en_ff[gi]),
        .level(level[gi]),
        .rise_pulse(rise_pulse[gi]),
        .fall_pulse(fall_pulse[gi])
      );
    end
  endgenerate

  // control registers
  always_comb begin
    for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
      nxt_en[ch] = en_ff[ch];
      nxt_pos_hyst[ch] = pos_hyst_ff[ch];
      nxt_neg_hyst[ch] = neg_hyst_ff[ch];
      nxt_rise_flag[ch] = rise_flag_ff[ch];
      nxt_fall_flag[ch] = fall_flag_ff[ch];
      if (wr_en && ctrl_hit(addr, ch)) begin
        nxt_en[ch] = wr_data[dcc_pkg::BIT_ENABLE];
        nxt_pos_hyst[ch] = wr_data[dcc_pkg::POS_HYST_HI:dcc_pkg::POS_HYST_LO];
        nxt_neg_hyst[ch] = wr_data[dcc_pkg::NEG_HYST_HI:dcc_pkg::NEG_HYST_LO];
        // a one written to a flag leaves it alone; software cannot fake an edge
        nxt_rise_flag[ch] = rise_flag_ff[ch] & wr_data[dcc_pkg::BIT_RISE_FLAG];
        nxt_fall_flag[ch] = fall_flag_ff[ch] & wr_data[dcc_pkg::BIT_FALL_FLAG];
      end
      if (rise_pulse[ch]) begin
        nxt_rise_flag[ch] = 1'b1;
      end
      if (fall_pulse[ch]) begin
        nxt_fall_flag[ch] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_ff <= 2'h0;
      rise_flag_ff <= 2'h0;
      fall_flag_ff <= 2'h0;
      for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
        pos_hyst_ff[ch] <= dcc_pkg::HYST_OFF;
        neg_hyst_ff[ch] <= dcc_pkg::HYST_OFF;
      end
    end else begin
      en_ff <= nxt_en;
      rise_flag_ff <= nxt_rise_flag;
      fall_flag_ff <= nxt_fall_flag;
      for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
        pos_hyst_ff[ch] <= nxt_pos_hyst[ch];
        neg_hyst_ff[ch] <= nxt_neg_hyst[ch];
      end
    end
  end

  // power-up settling, tracked so software can poll it instead of timing it
  always_comb begin
    for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
      nxt_settle_st[ch] = settle_st_ff[ch];
      nxt_settle_cnt[ch] = settle_cnt_ff[ch];
      if (!en_ff[ch]) begin
        nxt_settle_st[ch] = dcc_pkg::DCC_ST_OFF;
        nxt_settle_cnt[ch] = '0;
      end else begin
        case (settle_st_ff[ch])
          dcc_pkg::DCC_ST_OFF: begin
            nxt_settle_st[ch] = dcc_pkg::DCC_ST_SETTLING;
            nxt_settle_cnt[ch] = '0;
          end
          dcc_pkg::DCC_ST_SETTLING: begin
            if (settle_cnt_ff[ch] >= SETTLE_LAST) begin
              nxt_settle_st[ch] = dcc_pkg::DCC_ST_READY;
            end else begin
              nxt_settle_cnt[ch] = settle_cnt_ff[ch] + 1'b1;
            end
          end
          dcc_pkg::DCC_ST_READY: begin
            nxt_settle_st[ch] = dcc_pkg::DCC_ST_READY;
          end
          default: begin
            nxt_settle_st[ch] = dcc_pkg::DCC_ST_OFF;
            nxt_settle_cnt[ch] = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
        settle_st_ff[ch] <= dcc_pkg::DCC_ST_OFF;
        settle_cnt_ff[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
        settle_st_ff[ch] <= nxt_settle_st[ch];
        settle_cnt_ff[ch] <= nxt_settle_cnt[ch];
      end
    end
  end

  always_comb begin
    for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
      ready[ch] = (settle_st_ff[ch] == dcc_pkg::DCC_ST_READY);
    end
  end

  // interrupt status, mask and line
  always_comb begin
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask = irq_mask_ff;
    if (rd_en && addr == dcc_pkg::OFS_IRQ_STATUS) begin
      nxt_irq_status = dcc_pkg::IRQ_STATUS_RESET;
    end
    if (wr_en && addr == dcc_pkg::OFS_IRQ_MASK) begin
      nxt_irq_mask = wr_data[dcc_pkg::IRQ_W-1:0];
    end
    // set after clear: an edge in the read cycle survives
    for (int ch = 0; ch < dcc_pkg::NUM_CH; ch++) begin
      if (rise_pulse[ch]) begin
        nxt_irq_status[ch*dcc_pkg::IRQ_CH_STRIDE+dcc_pkg::IRQ_RISE_OFS] = 1'b1;
      end
      if (fall_pulse[ch]) begin
        nxt_irq_status[ch*dcc_pkg::IRQ_CH_STRIDE+dcc_pkg::IRQ_FALL_OFS] = 1'b1;
      end
    end
    nxt_irq = |(nxt_irq_status & nxt_irq_mask);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_status_ff <= dcc_pkg::IRQ_STATUS_RESET;
      irq_mask_ff <= dcc_pkg::IRQ_MASK_RESET;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
    end
  end

  // read data, port routing and reset request
  always_comb begin
    nxt_rd_data = 8'h00;
    if (rd_en) begin
      case (addr)
        dcc_pkg::OFS_CTRL0: begin
          nxt_rd_data = ctrl_image(en_ff[0], level[0] & en_ff[0], rise_flag_ff[0],
                                   fall_flag_ff[0], pos_hyst_ff[0], neg_hyst_ff[0]);
        end
        dcc_pkg::OFS_CTRL1: begin
          nxt_rd_data = ctrl_image(en_ff[1], level[1] & en_ff[1], rise_flag_ff[1],
                                   fall_flag_ff[1], pos_hyst_ff[1], neg_hyst_ff[1]);
        end
        dcc_pkg::OFS_IRQ_STATUS: begin
          nxt_rd_data = {4'h0, irq_status_ff};
        end
        dcc_pkg::OFS_IRQ_MASK: begin
          nxt_rd_data = {4'h0, irq_mask_ff};
        end
        dcc_pkg::OFS_READY: begin
          nxt_rd_data = {6'h00, ready};
        end
        default: begin
          nxt_rd_data = 8'h00;
        end
      endcase
    end
    nxt_port_out = en_ff & level;
    // low output of a settled, selected channel 0 asks for system reset
    nxt_reset_req = cmp0_reset_sel & en_ff[0] & ready[0] & ~level[0];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data_ff <= 8'h00;
      port_out_ff <= 2'h0;
      reset_req_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      port_out_ff <= nxt_port_out;
      reset_req_ff <= nxt_reset_req;
    end
  end

  assign rd_data = rd_data_ff;
  assign cmp_enable = en_ff;
  assign cmp0_pos_hyst_sel = pos_hyst_ff[0];
  assign cmp0_neg_hyst_sel = neg_hyst_ff[0];
  assign cmp1_pos_hyst_sel = pos_hyst_ff[1];
  assign cmp1_neg_hyst_sel = neg_hyst_ff[1];
  assign cmp_port_out = port_out_ff;
  // channel 1 has no reset path at all
  assign cmp0_reset_req = reset_req_ff;
  assign irq = irq_ff;

endmodule : dcc_top

// [verification/dcc_analog_model.sv]
`timescale 1ns/1ps
module dcc_analog_model (
  input wire logic [1:0] vin_above,
  output logic [1:0] cmp_raw
);
  // a shut-down core still toggles here, so gating is left to the block
  assign #13 cmp_raw = vin_above;
endmodule : dcc_analog_model

// [verification/dcc_top_monitor.sv]
`timescale 1ns/1ps
module dcc_top_monitor #(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] cmp_raw,
  input wire logic cmp0_reset_sel,
  input wire logic [1:0] cmp_enable,
  input wire logic [1:0] cmp0_pos_hyst_sel,
  input wire logic [1:0] cmp0_neg_hyst_sel,
  input wire logic [1:0] cmp1_pos_hyst_sel,
  input wire logic [1:0] cmp1_neg_hyst_sel,
  input wire logic [1:0] cmp_port_out,
  input wire logic cmp0_reset_req,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_rise0;
    cmp_raw[0] && !$past(cmp_raw[0]) && cmp_enable[0];
  endsequence
  sequence s_hold0;
    (cmp_raw[0] && cmp_enable[0]) [*2];
  endsequence

  AST_PORT_OFF: assert property ((cmp_port_out & ~$past(cmp_enable)) == 2'b00)
    else $error("port output high on disabled channel");
  AST_PORT_FOLLOW: assert property (s_rise0 ##1 s_hold0 |=> cmp_port_out[0])
    else $error("port output missed synchronised rise");
  AST_EN0_WRITE: assert property (wr_en && addr == 4'h0 |=> cmp_enable[0] == $past(wr_data[7]))
    else $error("channel 0 enable not taken from write");
  AST_EN1_WRITE: assert property (wr_en && addr == 4'h1 |=> cmp_enable[1] == $past(wr_data[7]))
    else $error("channel 1 enable not taken from write");
  AST_HYST0: assert property (wr_en && addr == 4'h0 |=>
    cmp0_pos_hyst_sel == $past(wr_data[3:2]) && cmp0_neg_hyst_sel == $past(wr_data[1:0]))
    else $error("channel 0 hysteresis code wrong");
  AST_HYST1: assert property (wr_en && addr == 4'h1 |=>
    cmp1_pos_hyst_sel == $past(wr_data[3:2]) && cmp1_neg_hyst_sel == $past(wr_data[1:0]))
    else $error("channel 1 hysteresis code wrong");
  AST_HYST1_HOLD: assert property (!(wr_en && addr == 4'h1) |=>
    $stable(cmp1_pos_hyst_sel) && $stable(cmp1_neg_hyst_sel))
    else $error("channel 1 hysteresis changed without write");
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not zero outside read");
  AST_RD_EN: assert property (rd_en && addr == 4'h0 |=> rd_data[7] == $past(cmp_enable[0]))
    else $error("read enable bit mismatch");
  AST_RESET_REQ: assert property (cmp0_reset_req |-> $past(cmp0_reset_sel && cmp_enable[0]))
    else $error("reset request without selection and enable");
endmodule : dcc_top_monitor

bind dcc_top dcc_top_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_dcc_top_monitor (
  .core_clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cmp_raw, .cmp0_reset_sel,
  .cmp_enable, .cmp0_pos_hyst_sel, .cmp0_neg_hyst_sel, .cmp1_pos_hyst_sel,
  .cmp1_neg_hyst_sel, .cmp_port_out, .cmp0_reset_req, .irq);

// [verification/dcc_top_tb_top.sv]
`timescale 1ns/1ps
module dcc_top_tb_top;
  localparam int unsigned SETTLE = 8;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cmp0_reset_sel = 1'b0;
  logic [1:0] vin_above = 2'b00;
  logic [7:0] rd_data;
  logic [1:0] cmp_raw, cmp_enable, ph0, nh0, ph1, nh1, cmp_port_out;
  logic cmp0_reset_req, irq;
  int bad_count = 0;
  int check_count = 0;

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  dcc_top #(.SETTLE_CYCLES(SETTLE)) i_dcc_top (.core_clk, .srst, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .cmp_raw, .cmp0_reset_sel, .cmp_enable, .cmp0_pos_hyst_sel(ph0),
    .cmp0_neg_hyst_sel(nh0), .cmp1_pos_hyst_sel(ph1), .cmp1_neg_hyst_sel(nh1),
    .cmp_port_out, .cmp0_reset_req, .irq);
  dcc_analog_model i_dcc_analog_model (.vin_above, .cmp_raw);

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk_reg("rd_data", exp, rd_data);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  // six cycles cover the three-cycle path from raw edge to irq
  task automatic drive_vin(input logic [1:0] v);
    @(posedge core_clk);
    vin_above <= v;
    settle(6);
  endtask : drive_vin

  task automatic set_sel(input logic v);
    @(posedge core_clk);
    cmp0_reset_sel <= v;
    settle(2);
    chk_pin("reset_req", {1'b0, v}, {1'b0, cmp0_reset_req});
  endtask : set_sel

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
    rd(4'hF, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {4'h0, 2'(c), 2'(3 - c)});
      wr(4'h1, {4'h0, 2'(3 - c), 2'(c)});
      settle(1);
      chk_pin("hyst0_pos", 2'(c), ph0);
      chk_pin("hyst0_neg", 2'(3 - c), nh0);
      chk_pin("hyst1_pos", 2'(3 - c), ph1);
      chk_pin("hyst1_neg", 2'(c), nh1);
      rd(4'h1, {4'h0, 2'(3 - c), 2'(c)});
    end
    wr(4'h0, 8'h70);
    rd(4'h0, 8'h00);
    wr(4'h3, 8'h0F);
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h80);
    settle(SETTLE + 4);
    rd(4'h4, 8'h03);
    drive_vin(2'b01);
    rd(4'h0, 8'hE0);
    chk_pin("port_out", 2'b01, cmp_port_out);
    chk_pin("irq", 2'b01, {1'b0, irq});
    rd(4'h1, 8'h80);
    rd(4'h2, 8'h01);
    rd(4'h2, 8'h00);
    chk_pin("irq", 2'b00, {1'b0, irq});
    drive_vin(2'b00);
    rd(4'h0, 8'hB0);
    set_sel(1'b1);
    set_sel(1'b0);
    wr(4'h0, 8'hB0);
    rd(4'h0, 8'hB0);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80);
    rd(4'h2, 8'h02);
    wr(4'h3, 8'h00);
    drive_vin(2'b10);
    chk_pin("irq", 2'b00, {1'b0, irq});
    rd(4'h2, 8'h04);
    rd(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    drive_vin(2'b11);
    rd(4'h0, 8'h00);
    chk_pin("port_out", 2'b10, cmp_port_out);
    rd(4'h2, 8'h00);
    // channel 1 falls in the very cycle a write clears its flags
    @(posedge core_clk);
    vin_above <= 2'b01;
    @(posedge core_clk);
    wr(4'h1, 8'h80);
    rd(4'h1, 8'h90);
    // second reset in mid-run, with flags and status set
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    chk_pin("port_out", 2'b00, cmp_port_out);
    tally_and_finish();
  end
endmodule : dcc_top_tb_top
